// ### verilog/bl_pkg.sv
// package: constants and types for the boot entry and packet handler
package bl_pkg;
  localparam logic [15:0] BL_LOADER_BASE = 16'h0000; // loader start address
  localparam logic [15:0] BL_LOADER_LAST = 16'h03ff;
  localparam logic [15:0] BL_APP_START = 16'h0400;
  localparam logic [15:0] BL_APP_LAST = 16'h3fff;
  localparam int BL_APP_SIZE = 15360;
  localparam logic [7:0] BL_HEADER = 8'haa;
  localparam logic [15:0] BL_READ_OK = 16'h0000;
  localparam logic [15:0] BL_READ_FAIL = 16'h0101;
  localparam int BL_PKT_BYTES = 5;
  localparam int BL_CLK_MHZ = 50;
  localparam int BL_DELAY_MS = 4; // startup pause, a few ms
  localparam int BL_DELAY_CYC = BL_DELAY_MS * 1000 * 1000 / 20;
  localparam logic [31:0] BL_DELAY_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    BL_ST_DELAY = 3'h0,
    BL_ST_SUM = 3'h1,
    BL_ST_DECIDE = 3'h2,
    BL_ST_CLEAR = 3'h3,
    BL_ST_IDLE = 3'h4,
    BL_ST_APP = 3'h5
  } bl_state_e;

  // one received command, also the basis of the answer
  typedef struct packed {
    logic [7:0] space;
    logic [7:0] reg_addr;
    logic [15:0] payload;
  } bl_cmd_s;
endpackage

// ### verilog/bl_boot.sv
// boot entry decision and five byte command/response handler
//
// Behaviour
// - execution starts at address zero
// - wait few milliseconds before entry decision
// - set entry flag forces loader mode
// - held reset button forces loader mode
// - bad image checksum forces loader mode
// - otherwise jump to application start address
// - application spans 0x0400 to 0x3fff
// - clear entry flag on loader entry
// - then idle waiting for command packets
// - message led solid while in loader
// - packets start with header byte 0xaa
// - byte three: direction bit, register index
// - one five byte answer per packet
// - answer byte two echoes namespace
// - answer byte three echoes address byte
// - write answer returns written value
// - read answer 0x0000 ok, 0x0101 failed
// - byte sum of image equals last byte
`timescale 1ns/100ps
module bl_boot
  import bl_pkg::*;
#(
  parameter int DELAY_CYC = BL_DELAY_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic entry_flag_i,
  input wire logic button_i,
  output logic entry_clear_o,
  output logic [15:0] mem_addr_o,
  input wire logic [7:0] mem_data_i,
  output logic jump_o,
  output logic [15:0] pc_o,
  output logic loader_o,
  output logic led_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic rx_ready_o,
  input wire logic read_fail_i,
  output logic cmd_valid_o,
  output logic [23:0] cmd_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] btn_q;
  logic [1:0] flag_q;
  // the button is an external pin: two stages before any use
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      btn_q <= 2'h0;
      flag_q <= 2'h0;
    end else begin
      btn_q <= {btn_q[0], button_i};
      flag_q <= {flag_q[0], entry_flag_i};
    end
  end

  // ---------------------------------------------------------------
  // boot sequencer
  // ---------------------------------------------------------------
  bl_state_e state_q;
  logic [31:0] dly_q;
  logic [15:0] addr_q;
  logic [7:0] sum_q;
  logic rd_ok_q;
  logic btn_cap_q;
  logic flag_cap_q;
  logic [15:0] pc_q;

  // memory is read one cycle after addr; rd_ok_q marks valid data
  assign mem_addr_o = addr_q;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_q <= BL_ST_DELAY;
      dly_q <= BL_DELAY_RST;
      addr_q <= BL_APP_START;
      sum_q <= 8'h00;
      rd_ok_q <= 1'b0;
      btn_cap_q <= 1'b0;
      flag_cap_q <= 1'b0;
      pc_q <= BL_LOADER_BASE;
    end else begin
      unique case (state_q)
        BL_ST_DELAY: begin
          dly_q <= dly_q + 32'h1;
          if (dly_q >= 32'(DELAY_CYC - 1)) begin
            btn_cap_q <= btn_q[1];
            flag_cap_q <= flag_q[1];
            state_q <= BL_ST_SUM;
          end
        end
        BL_ST_SUM: begin
          // sum 0x0400..0x3ffe; the byte at 0x3fff is the reference
          rd_ok_q <= 1'b1;
          if (rd_ok_q && addr_q != BL_APP_LAST + 16'h1) begin
            sum_q <= sum_q + mem_data_i;
          end
          if (addr_q == BL_APP_LAST) begin
            state_q <= BL_ST_DECIDE;
          end else begin
            addr_q <= addr_q + 16'h1;
          end
        end
        BL_ST_DECIDE: begin
          // mem_data_i now holds the byte at the last image address
          if (flag_cap_q || btn_cap_q || sum_q != mem_data_i) begin
            state_q <= BL_ST_CLEAR;
          end else begin
            pc_q <= BL_APP_START;
            state_q <= BL_ST_APP;
          end
        end
        BL_ST_CLEAR: state_q <= BL_ST_IDLE;
        BL_ST_IDLE: state_q <= BL_ST_IDLE;
        BL_ST_APP: state_q <= BL_ST_APP;
        default: state_q <= BL_ST_DELAY;
      endcase
    end
  end

  // summing stops one early: last summed read is address 0x3ffe
  // (the read issued with addr 0x3fff is the reference byte)

  assign entry_clear_o = (state_q == BL_ST_CLEAR);
  assign jump_o = (state_q == BL_ST_APP);
  assign pc_o = pc_q;
  assign loader_o = (state_q == BL_ST_IDLE);
  assign led_o = (state_q == BL_ST_IDLE); // solid, no blink

  // ---------------------------------------------------------------
  // receive: hunt header, gather four bytes
  // ---------------------------------------------------------------
  logic [2:0] rx_cnt_q;
  bl_cmd_s cmd_q;
  logic busy_q; // an answer is in flight
  logic take;

  // no new bytes taken while answering, so answers never interleave
  assign rx_ready_o = loader_o && !busy_q;
  assign take = rx_valid_i && rx_ready_o;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rx_cnt_q <= 3'h0;
      cmd_q <= '0;
    end else if (take) begin
      unique case (rx_cnt_q)
        3'h0: if (rx_data_i == BL_HEADER) rx_cnt_q <= 3'h1;
        3'h1: begin
          cmd_q.space <= rx_data_i;
          rx_cnt_q <= 3'h2;
        end
        3'h2: begin
          cmd_q.reg_addr <= rx_data_i;
          rx_cnt_q <= 3'h3;
        end
        3'h3: begin
          cmd_q.payload[7:0] <= rx_data_i;
          rx_cnt_q <= 3'h4;
        end
        3'h4: begin
          cmd_q.payload[15:8] <= rx_data_i;
          rx_cnt_q <= 3'h0;
        end
        default: rx_cnt_q <= 3'h0;
      endcase
    end
  end

  logic done_q;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= take && rx_cnt_q == 3'h4;
    end
  end

  // decoded command offered to the register logic for one cycle
  assign cmd_valid_o = done_q;
  assign cmd_o = {cmd_q.space, cmd_q.reg_addr, cmd_q.payload[7:0]};

  // ---------------------------------------------------------------
  // transmit: header, space, address, payload low, high
  // ---------------------------------------------------------------
  logic [2:0] tx_cnt_q;
  logic [7:0] tx_q;
  logic [15:0] ans_q;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      busy_q <= 1'b0;
      tx_cnt_q <= 3'h0;
      ans_q <= 16'h0000;
    end else if (done_q) begin
      busy_q <= 1'b1;
      tx_cnt_q <= 3'h0;
      if (cmd_q.reg_addr[7]) begin
        ans_q <= cmd_q.payload;
      end else begin
        ans_q <= read_fail_i ? BL_READ_FAIL : BL_READ_OK;
      end
    end else if (busy_q && tx_ready_i) begin
      if (tx_cnt_q == 3'(BL_PKT_BYTES - 1)) begin
        busy_q <= 1'b0;
      end
      tx_cnt_q <= tx_cnt_q + 3'h1;
    end
  end

  // next byte is loaded as the current one is taken, so data leaves a flop
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tx_q <= 8'h00;
    end else if (done_q) begin
      tx_q <= BL_HEADER;
    end else if (busy_q && tx_ready_i) begin
      unique case (tx_cnt_q)
        3'h0: tx_q <= cmd_q.space;
        3'h1: tx_q <= cmd_q.reg_addr;
        3'h2: tx_q <= ans_q[7:0];
        default: tx_q <= ans_q[15:8];
      endcase
    end
  end

  assign tx_valid_o = busy_q;
  assign tx_data_o = tx_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_led_solid;
    @(posedge mclk_i) disable iff (reset_i)
    loader_o |-> led_o ##1 led_o;
  endproperty
  a_led_solid: assert property (p_led_solid)
    else $error("led not solid in loader mode");

  property p_clear_then_idle;
    @(posedge mclk_i) disable iff (reset_i)
    entry_clear_o |=> loader_o && !entry_clear_o;
  endproperty
  a_clear_then_idle: assert property (p_clear_then_idle)
    else $error("loader idle not after flag clear");

  property p_idle_after_clear;
    @(posedge mclk_i) disable iff (reset_i)
    $rose(loader_o) |-> $past(entry_clear_o);
  endproperty
  a_idle_after_clear: assert property (p_idle_after_clear)
    else $error("loader entered without clearing flag");

  property p_jump_pc;
    @(posedge mclk_i) disable iff (reset_i)
    jump_o |-> pc_o == BL_APP_START;
  endproperty
  a_jump_pc: assert property (p_jump_pc)
    else $error("jump without application address");

  property p_flag_forces_loader;
    @(posedge mclk_i) disable iff (reset_i)
    state_q == BL_ST_DECIDE && flag_cap_q |=> entry_clear_o;
  endproperty
  a_flag_forces_loader: assert property (p_flag_forces_loader)
    else $error("entry flag did not force loader");

  property p_btn_forces_loader;
    @(posedge mclk_i) disable iff (reset_i)
    state_q == BL_ST_DECIDE && btn_cap_q |=> !jump_o;
  endproperty
  a_btn_forces_loader: assert property (p_btn_forces_loader)
    else $error("button did not force loader");

  property p_sum_bad;
    @(posedge mclk_i) disable iff (reset_i)
    state_q == BL_ST_DECIDE && sum_q != mem_data_i |=> entry_clear_o;
  endproperty
  a_sum_bad: assert property (p_sum_bad)
    else $error("bad checksum did not force loader");

  property p_answer_header;
    @(posedge mclk_i) disable iff (reset_i)
    done_q |=> tx_valid_o && tx_data_o == BL_HEADER;
  endproperty
  a_answer_header: assert property (p_answer_header)
    else $error("answer does not open with header");

  property p_no_rx_while_tx;
    @(posedge mclk_i) disable iff (reset_i)
    tx_valid_o |-> !rx_ready_o;
  endproperty
  a_no_rx_while_tx: assert property (p_no_rx_while_tx)
    else $error("receive open during answer");

  property p_echo_addr;
    @(posedge mclk_i) disable iff (reset_i)
    tx_valid_o && tx_cnt_q == 3'h2 |-> tx_data_o == cmd_q.reg_addr;
  endproperty
  a_echo_addr: assert property (p_echo_addr)
    else $error("address byte not echoed");

  c_loader: cover property (@(posedge mclk_i) $rose(loader_o));
  c_app: cover property (@(posedge mclk_i) $rose(jump_o));
  c_answer: cover property (@(posedge mclk_i) $fell(busy_q));

endmodule // bl_boot

// ### testbench/bl_host_mem.sv
// image store model with one cycle read latency
`timescale 1ns/100ps
module bl_host_mem
  import bl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic bad_i,
  output logic [7:0] mem_data_o
);
  logic [7:0] sum_q;

  // content varies with address so a wrong span breaks the sum
  function automatic logic [7:0] img(input logic [15:0] a);
    return a[7:0] ^ {2'h0, a[13:8]};
  endfunction

  // reference sum worked out once, before any read
  initial begin
    sum_q = 8'h00;
    for (int a = 16'h0400; a < 16'h3fff; a++) begin
      sum_q = sum_q + img(16'(a));
    end
  end

  // bad_i corrupts only the stored check byte
  always_ff @(posedge mclk_i) begin
    if (mem_addr_i == BL_APP_LAST) begin
      mem_data_o <= sum_q + {7'h00, bad_i};
    end else begin
      mem_data_o <= img(mem_addr_i);
    end
  end
endmodule // bl_host_mem

// ### testbench/tb.sv
// testbench: boot decision and packet answers
`timescale 1ns/100ps
module tb
  import bl_pkg::*;
;
  localparam logic [7:0] NS_LOADER = 8'h05;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic flag = 1'b0;
  logic btn = 1'b0;
  logic bad = 1'b0;
  logic fail = 1'b0;
  logic rx_valid = 1'b0;
  logic tx_ready = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic clr, jump, loader, led, rx_ready, cmd_valid, tx_valid;
  logic [15:0] mem_addr, pc;
  logic [7:0] mem_data, tx_data;
  logic [23:0] cmd, cmd_seen;
  int err_total = 0;
  int samples_checked = 0;
  int clr_cnt = 0;

  always #10 mclk_i = ~mclk_i;

  bl_boot #(.DELAY_CYC(4)) i_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .entry_flag_i(flag),
    .button_i(btn), .entry_clear_o(clr), .mem_addr_o(mem_addr),
    .mem_data_i(mem_data), .jump_o(jump), .pc_o(pc), .loader_o(loader),
    .led_o(led), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .rx_ready_o(rx_ready), .read_fail_i(fail), .cmd_valid_o(cmd_valid),
    .cmd_o(cmd), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
    .tx_ready_i(tx_ready));

  bl_host_mem i_mem (.mclk_i(mclk_i), .mem_addr_i(mem_addr), .bad_i(bad),
    .mem_data_o(mem_data));

  // pulses are seen mid-cycle where they have settled
  always @(negedge mclk_i) begin
    if (clr === 1'b1) clr_cnt++;
    if (cmd_valid === 1'b1) cmd_seen = cmd;
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic boot(input logic f, b, x, ld);
    int n;
    reset_i = 1'b1;
    flag = f;
    btn = b;
    bad = x;
    repeat (16) @(negedge mclk_i);
    chk(pc, BL_LOADER_BASE);
    clr_cnt = 0;
    reset_i = 1'b0;
    n = 0;
    while (jump !== 1'b1 && loader !== 1'b1 && n < 20000) begin
      @(negedge mclk_i);
      n++;
    end
    repeat (4) @(negedge mclk_i);
    chk(n >= BL_APP_SIZE + 4, 1'b1);
    chk(loader, ld);
    chk(jump, !ld);
    chk(pc, ld ? BL_LOADER_BASE : BL_APP_START);
    chk(led, ld);
    chk(24'(clr_cnt), ld);
  endtask

  // request held from one negedge until the edge that takes it
  task automatic send(input logic [7:0] d);
    int n;
    n = 0;
    rx_data = d;
    rx_valid = 1'b1;
    while (rx_ready !== 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    @(negedge mclk_i);
  endtask

  task automatic pkt(input logic [7:0] ad, lo, hi, input logic fl,
                     input logic [15:0] exp);
    logic [7:0] got [5];
    int n;
    fail = fl;
    send(8'h3c); // stray byte ahead of the header, must be dropped
    send(BL_HEADER);
    send(NS_LOADER);
    send(ad);
    send(lo);
    send(hi);
    rx_valid = 1'b0;
    // one stall cycle between bytes exercises the hold
    for (int i = 0; i < 5; i++) begin
      n = 0;
      while (tx_valid !== 1'b1 && n < 100) begin
        @(negedge mclk_i);
        n++;
      end
      got[i] = tx_data;
      tx_ready = 1'b1;
      @(negedge mclk_i);
      tx_ready = 1'b0;
      @(negedge mclk_i);
    end
    chk(cmd_seen, {NS_LOADER, ad, lo});
    chk(got[0], BL_HEADER);
    chk(got[1], NS_LOADER);
    chk(got[2], ad);
    chk({got[4], got[3]}, exp);
    chk(tx_valid, 1'b0);
  endtask

  initial begin
    boot(1'b0, 1'b0, 1'b0, 1'b0);
    boot(1'b1, 1'b0, 1'b0, 1'b1);
    boot(1'b0, 1'b1, 1'b0, 1'b1);
    boot(1'b0, 1'b0, 1'b1, 1'b1);
    pkt(8'h82, 8'h5a, 8'hc3, 1'b0, 16'hc35a);
    pkt(8'h01, 8'h00, 8'h00, 1'b0, BL_READ_OK);
    pkt(8'h7f, 8'h00, 8'h00, 1'b1, BL_READ_FAIL);
    pkt(8'hff, 8'hff, 8'h00, 1'b1, 16'h00ff);
    print_verdict();
  end

  // four boots of about 15400 cycles plus packets fit well inside
  initial begin
    #(90000 * 20);
    err_total++;
    print_verdict();
  end
endmodule // tb
